// [shared/asf_pkg.sv]
// Shared constants, register map and carrier types for the axis and spindle status flags
package asf_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_AXES  = 3;
    localparam int VAL_W     = 16;
    localparam int LETTER_W  = 3;
    localparam int RANK_W    = 2;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_AXIS_CFG  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_SPIN_CFG  = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_MIN_MOVE  = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_GANTRY    = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_SPD_LOW   = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_SPD_HIGH  = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h18;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int EXIST_LSB    = 0;
    localparam int LETTER_LSB   = 4;
    localparam int LETTER_STEP  = 4;
    localparam int SP_MODE_LSB  = 0;
    localparam int SP_SEL_BIT   = 4;
    localparam int ST_SLOT_STEP = 8;
    localparam int ST_ALL_BIT   = 24;
    localparam int ST_SPIN_LSB  = 25;

    localparam logic [DATA_W-1:0] AXIS_CFG_RST = 32'h0000_2107;
    localparam logic [VAL_W-1:0]  MIN_MOVE_RST = 16'h0000;
    localparam logic [VAL_W-1:0]  GANTRY_RST   = 16'hFFFF;
    localparam logic [VAL_W-1:0]  SPD_LOW_RST  = 16'h0000;
    localparam logic [VAL_W-1:0]  SPD_HIGH_RST = 16'hFFFF;

    // ------------------------------------------------------------------
    // Spindle modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ASF_SP_OPEN   = 2'h0,
        ASF_SP_CW     = 2'h1,
        ASF_SP_CCW    = 2'h2,
        ASF_SP_CLOSED = 2'h3
    } asf_sp_mode_t;

    localparam asf_sp_mode_t SP_MODE_RST = ASF_SP_OPEN;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic             permit;
        logic             dir_neg;
        logic             home_done;
        logic             fb_alarm;
        logic             direct_fb;
        logic             gantry_active;
        logic [VAL_W-1:0] gantry_diff;
        logic [VAL_W-1:0] move_len;
        logic             in_pos;
        logic [1:0]       drive_state;
        logic             drive_error;
    } asf_axis_in_t;

    typedef struct packed {
        logic move_permit;
        logic negative_motion;
        logic homed;
        logic drive_state_hi;
        logic drive_state_lo;
        logic gantry_mismatch;
        logic short_move;
        logic settled;
    } asf_axis_flags_t;

    typedef struct packed {
        logic             permit;
        logic             dir_neg;
        logic             home_done;
        logic             count_loss;
        logic [VAL_W-1:0] speed;
        logic             stopped;
        logic             in_pos;
        logic [1:0]       drive_state;
        logic             drive_error;
    } asf_spin_in_t;

    typedef struct packed {
        logic move_permit;
        logic negative_motion;
        logic homed;
        logic drive_state_hi;
        logic drive_state_lo;
        logic speed_match;
        logic settled;
    } asf_spin_flags_t;

endpackage

// [rtl/asf_status_flags.sv]
// Axis and spindle status flags presented to the PLC, with an APB register slave
//
// Function
// - Slots without an existing axis show all flags equal to the zero constant.
// - Slots 1 to 3 follow logical axis order by configured letter value, not channel number.
// - Axis move-permit flag high tells the PLC to let the axis move.
// - Axis negative-motion flag high for negative travel, low for positive.
// - Axis homed flag rises after reference search; low forces a new search.
// - Homed clears on power-up, shift-reset, direct feedback alarm, config change.
// - Axis drive pair encodes 00 start, 01 ready, 10 bus powered, 11 torque.
// - Drive internal error forces both drive-state flags low.
// - Gantry mismatch high when master-slave difference exceeds configured maximum.
// - Short-move flag high when commanded move is below the minimum threshold.
// - Axis settled flag high while the axis is in position.
// - All-axes settled flag high once every axis is in position.
// - Spindle move-permit only in closed loop, for the selected spindle.
// - Spindle negative-motion flag shows direction in closed loop.
// - Spindle homed sticky; clears on power-up, shift-reset, count loss, leaving closed loop.
// - Spindle drive pair uses the same four-state encoding as the axes.
// - In CW or CCW mode speed match high while speed is inside window.
// - In closed loop speed match high while the spindle is stopped.
// - Spindle settled high in closed loop for the selected spindle in position.
//
// Decided for this implementation: the APB slave port and the register offsets.
module asf_status_flags
    import asf_pkg::*;
(
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic [asf_pkg::ADDR_W-1:0]       paddr,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [asf_pkg::DATA_W-1:0]       pwdata,
    output logic      [asf_pkg::DATA_W-1:0]       prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire asf_pkg::asf_axis_in_t            axis_in [asf_pkg::NUM_AXES],
    input  wire asf_pkg::asf_spin_in_t            spin_in,
    input  wire logic                             shift_reset_evt,
    output asf_pkg::asf_axis_flags_t              axis_flags [asf_pkg::NUM_AXES],
    output logic                                  all_axes_settled,
    output asf_pkg::asf_spin_flags_t              spin_flags,
    output logic                                  constant_zero_flag
);
    import asf_pkg::*;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [DATA_W-1:0]     axis_cfg_q, axis_cfg_d;
    asf_sp_mode_t          sp_mode_q, sp_mode_d;
    logic                  sp_sel_q, sp_sel_d;
    logic [VAL_W-1:0]      min_move_q, min_move_d;
    logic [VAL_W-1:0]      gantry_max_q, gantry_max_d;
    logic [VAL_W-1:0]      spd_low_q, spd_low_d;
    logic [VAL_W-1:0]      spd_high_q, spd_high_d;
    logic [DATA_W-1:0]     prdata_q, prdata_d;
    logic                  pready_q, pready_d;
    logic                  pslverr_q, pslverr_d;
    logic [NUM_AXES-1:0]   homed_q, homed_d;
    logic                  sp_homed_q, sp_homed_d;
    asf_axis_flags_t       slot_q [NUM_AXES];
    asf_axis_flags_t       slot_d [NUM_AXES];
    logic                  all_q, all_d;
    asf_spin_flags_t       spf_q, spf_d;

    logic [NUM_AXES-1:0]   exists;
    logic [LETTER_W-1:0]   letter [NUM_AXES];
    logic [RANK_W-1:0]     rank [NUM_AXES];
    asf_axis_flags_t       chan_f [NUM_AXES];
    logic                  wr_en;
    logic                  cfg_change;
    logic [DATA_W-1:0]     status_word;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // The answer comes one cycle into the access phase; writes land on the next edge, while pready is high
    assign wr_en = psel && penable && pready_q && pwrite;

    // Register write and read-back
    always_comb begin
        axis_cfg_d   = axis_cfg_q;
        sp_mode_d    = sp_mode_q;
        sp_sel_d     = sp_sel_q;
        min_move_d   = min_move_q;
        gantry_max_d = gantry_max_q;
        spd_low_d    = spd_low_q;
        spd_high_d   = spd_high_q;
        pready_d     = psel && penable && !pready_q;
        prdata_d     = prdata_q;
        pslverr_d    = 1'b0;
        if (psel && penable && !pready_q) begin
            prdata_d = '0;
            case (paddr)
                ADDR_AXIS_CFG: prdata_d = axis_cfg_q;
                ADDR_SPIN_CFG: prdata_d = {27'h0, sp_sel_q, 2'h0, sp_mode_q};
                ADDR_MIN_MOVE: prdata_d = {16'h0, min_move_q};
                ADDR_GANTRY:   prdata_d = {16'h0, gantry_max_q};
                ADDR_SPD_LOW:  prdata_d = {16'h0, spd_low_q};
                ADDR_SPD_HIGH: prdata_d = {16'h0, spd_high_q};
                ADDR_STATUS:   prdata_d = status_word;
                default:       pslverr_d = 1'b1;
            endcase
        end
        if (wr_en) begin
            case (paddr)
                ADDR_AXIS_CFG: axis_cfg_d = pwdata;
                ADDR_SPIN_CFG: begin
                    sp_mode_d = asf_sp_mode_t'(pwdata[SP_MODE_LSB +: 2]);
                    sp_sel_d  = pwdata[SP_SEL_BIT];
                end
                ADDR_MIN_MOVE: min_move_d   = pwdata[VAL_W-1:0];
                ADDR_GANTRY:   gantry_max_d = pwdata[VAL_W-1:0];
                ADDR_SPD_LOW:  spd_low_d    = pwdata[VAL_W-1:0];
                ADDR_SPD_HIGH: spd_high_d   = pwdata[VAL_W-1:0];
                default:       ;
            endcase
        end
    end

    // Register stage for the bus and configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            axis_cfg_q   <= AXIS_CFG_RST;
            sp_mode_q    <= SP_MODE_RST;
            sp_sel_q     <= 1'b1;
            min_move_q   <= MIN_MOVE_RST;
            gantry_max_q <= GANTRY_RST;
            spd_low_q    <= SPD_LOW_RST;
            spd_high_q   <= SPD_HIGH_RST;
            prdata_q     <= '0;
            pready_q     <= 1'b0;
            pslverr_q    <= 1'b0;
        end else begin
            axis_cfg_q   <= axis_cfg_d;
            sp_mode_q    <= sp_mode_d;
            sp_sel_q     <= sp_sel_d;
            min_move_q   <= min_move_d;
            gantry_max_q <= gantry_max_d;
            spd_low_q    <= spd_low_d;
            spd_high_q   <= spd_high_d;
            prdata_q     <= prdata_d;
            pready_q     <= pready_d;
            pslverr_q    <= pslverr_d;
        end
    end

    // Changing the axis layout invalidates every axis reference search
    assign cfg_change = wr_en && (paddr == ADDR_AXIS_CFG) && (pwdata != axis_cfg_q);

    // ------------------------------------------------------------------
    // Per-channel flags and logical ordering
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_AXES; gi++) begin : g_chan
            assign exists[gi] = axis_cfg_q[EXIST_LSB + gi];
            assign letter[gi] = axis_cfg_q[LETTER_LSB + gi*LETTER_STEP +: LETTER_W];

            always_comb begin
                rank[gi] = '0;
                for (int j = 0; j < NUM_AXES; j++) begin
                    if (exists[j] && ((letter[j] < letter[gi]) ||
                                      ((letter[j] == letter[gi]) && (j < gi)))) begin
                        rank[gi] = rank[gi] + 2'h1;
                    end
                end
            end

            // clear sources, a finished search wins
            always_comb begin
                homed_d[gi] = homed_q[gi];
                if (shift_reset_evt || cfg_change ||
                    (axis_in[gi].fb_alarm && axis_in[gi].direct_fb)) begin
                    homed_d[gi] = 1'b0;
                end
                if (axis_in[gi].home_done) begin
                    homed_d[gi] = 1'b1;
                end
            end

            // Channel flag word before slot mapping
            always_comb begin
                chan_f[gi].move_permit     = axis_in[gi].permit;
                chan_f[gi].negative_motion = axis_in[gi].dir_neg;
                chan_f[gi].homed           = homed_d[gi];
                chan_f[gi].drive_state_hi  = axis_in[gi].drive_state[1] &&
                                             !axis_in[gi].drive_error;
                chan_f[gi].drive_state_lo  = axis_in[gi].drive_state[0] &&
                                             !axis_in[gi].drive_error;
                chan_f[gi].gantry_mismatch = axis_in[gi].gantry_active &&
                                             (axis_in[gi].gantry_diff > gantry_max_q);
                chan_f[gi].short_move      = axis_in[gi].move_len < min_move_q;
                chan_f[gi].settled         = axis_in[gi].in_pos;
            end
        end
    endgenerate

    always_comb begin
        all_d = |exists;
        for (int s = 0; s < NUM_AXES; s++) begin
            slot_d[s] = '0;
            for (int i = 0; i < NUM_AXES; i++) begin
                if (exists[i] && (int'(rank[i]) == s)) begin
                    slot_d[s] = chan_f[i];
                end
            end
        end
        for (int i = 0; i < NUM_AXES; i++) begin
            if (exists[i] && !axis_in[i].in_pos) begin
                all_d = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Spindle
    // ------------------------------------------------------------------
    // sticky homed, cleared on reset sequence, count loss or leaving closed loop
    // drive pair shares the axis encoding
    always_comb begin
        sp_homed_d = sp_homed_q;
        if (shift_reset_evt || spin_in.count_loss ||
            ((sp_mode_q == ASF_SP_CLOSED) && (sp_mode_d != ASF_SP_CLOSED))) begin
            sp_homed_d = 1'b0;
        end
        if (spin_in.home_done && sp_sel_q) begin
            sp_homed_d = 1'b1;
        end
        spf_d = '0;
        spf_d.homed          = sp_homed_d;
        spf_d.drive_state_hi = spin_in.drive_state[1] && !spin_in.drive_error;
        spf_d.drive_state_lo = spin_in.drive_state[0] && !spin_in.drive_error;
        if (sp_sel_q) begin
            case (sp_mode_q)
                ASF_SP_CW, ASF_SP_CCW: begin
                    spf_d.speed_match = (spin_in.speed >= spd_low_q) &&
                                        (spin_in.speed <= spd_high_q);
                end
                ASF_SP_CLOSED: begin
                    spf_d.move_permit     = spin_in.permit;
                    spf_d.negative_motion = spin_in.dir_neg;
                    spf_d.speed_match     = spin_in.stopped;
                    spf_d.settled         = spin_in.in_pos;
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Flag registers
    // ------------------------------------------------------------------
    // registered flags, low after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            homed_q    <= '0;
            sp_homed_q <= 1'b0;
            all_q      <= 1'b0;
            spf_q      <= '0;
            for (int s = 0; s < NUM_AXES; s++) begin
                slot_q[s] <= '0;
            end
        end else begin
            homed_q    <= homed_d;
            sp_homed_q <= sp_homed_d;
            all_q      <= all_d;
            spf_q      <= spf_d;
            for (int s = 0; s < NUM_AXES; s++) begin
                slot_q[s] <= slot_d[s];
            end
        end
    end

    // Status read-back of the presented flags
    always_comb begin
        status_word = '0;
        for (int s = 0; s < NUM_AXES; s++) begin
            status_word[s*ST_SLOT_STEP +: 8] = slot_q[s];
        end
        status_word[ST_ALL_BIT]            = all_q;
        status_word[ST_SPIN_LSB +: 7]      = spf_q;
    end

    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign all_axes_settled   = all_q;
    assign spin_flags         = spf_q;
    assign constant_zero_flag = 1'b0;
    generate
        for (gi = 0; gi < NUM_AXES; gi++) begin : g_out
            assign axis_flags[gi] = slot_q[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    absent_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(&exists) |=> (slot_q[2] == '0))
        else $error("flags present on a slot with no axis");

    slot_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        (exists == 3'h5) && (letter[0] > letter[2])
        |=> slot_q[0].settled == $past(axis_in[2].in_pos))
        else $error("slot zero not taken by lowest letter axis");

    drive_error_a: assert property (@(posedge pclk) disable iff (!presetn)
        spin_in.drive_error |=> !spf_q.drive_state_hi && !spf_q.drive_state_lo)
        else $error("drive state not forced low on drive error");

    shift_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        shift_reset_evt && (axis_in[0].home_done == 1'b0) && exists[0]
        && (rank[0] == 2'h0) |=> !slot_q[0].homed)
        else $error("axis homed flag survived shift reset");

    spin_homed_a: assert property (@(posedge pclk) disable iff (!presetn)
        spin_in.home_done && sp_sel_q ##1 !shift_reset_evt && !spin_in.count_loss
        && (sp_mode_q == sp_mode_d) |=> spf_q.homed)
        else $error("spindle homed flag lost without a clearing cause");

    speed_window_a: assert property (@(posedge pclk) disable iff (!presetn)
        sp_sel_q && (sp_mode_q inside {ASF_SP_CW, ASF_SP_CCW}) && (spin_in.speed >= spd_low_q)
        && (spin_in.speed <= spd_high_q) |=> spf_q.speed_match)
        else $error("speed match missing inside window");

    closed_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        sp_sel_q && (sp_mode_q == ASF_SP_CLOSED) |=> spf_q.speed_match == $past(spin_in.stopped))
        else $error("closed loop speed match does not follow stop");

    open_permit_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sp_mode_q != ASF_SP_CLOSED) || !sp_sel_q |=> !spf_q.move_permit && !spf_q.settled)
        else $error("spindle permit outside closed loop");

    all_settled_a: assert property (@(posedge pclk) disable iff (!presetn)
        exists[1] && !axis_in[1].in_pos |=> !all_q)
        else $error("all settled while an axis is out of position");

    bus_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready_q |=> pready_q ##1 !pready_q)
        else $error("access phase not answered in one cycle");

    dir_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        exists[0] && (rank[0] == 2'h0)
        |=> slot_q[0].negative_motion == $past(axis_in[0].dir_neg))
        else $error("slot direction does not follow its axis");

    short_move_a: assert property (@(posedge pclk) disable iff (!presetn)
        exists[1] && (rank[1] == 2'h1) && (axis_in[1].move_len < min_move_q)
        |=> slot_q[1].short_move)
        else $error("short move not flagged below threshold");

endmodule

// [verification/asf_plc_model.sv]
// Behavioural PLC that latches the move permissions it reads
module asf_plc_model
    import asf_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire asf_pkg::asf_axis_flags_t axis_flags [asf_pkg::NUM_AXES],
    input  wire asf_pkg::asf_spin_flags_t spin_flags,
    output logic      [3:0]               drive_on_q
);
    timeunit 1ns;
    timeprecision 1ns;
    // Power stage follows the permits one cycle late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_on_q <= 4'h0;
        end else begin
            drive_on_q <= {spin_flags.move_permit, axis_flags[2].move_permit,
                           axis_flags[1].move_permit, axis_flags[0].move_permit};
        end
    end
endmodule

// [verification/asf_status_flags_tb.sv]
// Self-checking bench for the axis and spindle status flags
module axis_spindle_status_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import asf_pkg::*;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    asf_axis_in_t      ax [NUM_AXES] = '{default: '0};
    asf_spin_in_t      sp = '0;
    logic              shift_reset_evt = 1'b0;
    asf_axis_flags_t   af [NUM_AXES];
    logic              all_set;
    asf_spin_flags_t   sf;
    logic              zero_flag;
    logic [3:0]        plc_on;
    logic [DATA_W-1:0] rd;
    logic              err;
    int                fail_count = 0;
    int                n_tests = 0;

    // ----------------------------------------------------------
    // Clock, design and far side
    // ----------------------------------------------------------
    always #50 pclk = ~pclk;
    asf_status_flags dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .axis_in(ax), .spin_in(sp),
        .shift_reset_evt(shift_reset_evt), .axis_flags(af), .all_axes_settled(all_set),
        .spin_flags(sf), .constant_zero_flag(zero_flag));
    asf_plc_model plc (.pclk(pclk), .presetn(presetn), .axis_flags(af),
        .spin_flags(sf), .drive_on_q(plc_on));

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t %s seen %0h want %0h", $time, what, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            complete_run();
        end
    endtask
    task automatic home_axis0();
        ax[0].home_done <= 1'b1;
        tick(1);
        ax[0].home_done <= 1'b0;
        tick(2);
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_regs();
        apb(1'b0, ADDR_AXIS_CFG, '0);
        chk(rd, AXIS_CFG_RST, "axis cfg reset");
        apb(1'b0, 8'h1C, '0);
        chk({31'h0, err}, 32'h1, "unmapped err");
        chk(rd, 32'h0, "unmapped data");
    endtask
    task automatic t_axes();
        ax[0].permit <= 1'b1;
        ax[0].dir_neg <= 1'b1;
        ax[0].in_pos <= 1'b1;
        ax[0].drive_state <= 2'b10;
        ax[1].drive_state <= 2'b01;
        ax[1].drive_error <= 1'b1;
        tick(3);
        chk(32'(af[0]), 32'hD1, "axis0 flags");
        chk(32'(af[1]), 32'h00, "drive error");
        chk(32'(all_set), 32'h0, "part settled");
        chk(32'(plc_on), 32'h1, "plc permit");
        ax[1].drive_error <= 1'b0;
        ax[1].in_pos <= 1'b1;
        ax[2].in_pos <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            ax[2].drive_state <= 2'(c);
            tick(2);
            chk({30'h0, af[2].drive_state_hi, af[2].drive_state_lo}, 32'(c), "code");
        end
        chk(32'(af[1]), 32'h09, "axis1 ready");
        chk(32'(all_set), 32'h1, "all settled");
    endtask
    task automatic t_limits();
        apb(1'b1, ADDR_MIN_MOVE, 32'h10);
        apb(1'b1, ADDR_GANTRY, 32'h64);
        apb(1'b0, ADDR_GANTRY, '0);
        chk(rd, 32'h64, "gantry max");
        ax[1].move_len <= 16'h000F;
        ax[2].gantry_active <= 1'b1;
        ax[2].gantry_diff <= 16'h0065;
        tick(2);
        chk(32'(af[1].short_move), 32'h1, "short");
        chk(32'(af[2].gantry_mismatch), 32'h1, "gantry");
        ax[1].move_len <= 16'h0010;
        ax[2].gantry_diff <= 16'h0064;
        tick(2);
        chk(32'(af[1].short_move), 32'h0, "short edge");
        chk(32'(af[2].gantry_mismatch), 32'h0, "gantry edge");
        apb(1'b1, ADDR_MIN_MOVE, 32'h0);
    endtask
    task automatic t_homing();
        home_axis0();
        chk(32'(af[0].homed), 32'h1, "homed");
        shift_reset_evt <= 1'b1;
        tick(1);
        shift_reset_evt <= 1'b0;
        tick(2);
        chk(32'(af[0].homed), 32'h0, "shift reset");
        home_axis0();
        ax[0].fb_alarm <= 1'b1;
        ax[0].direct_fb <= 1'b1;
        tick(1);
        ax[0].fb_alarm <= 1'b0;
        tick(2);
        chk(32'(af[0].homed), 32'h0, "fb alarm");
        home_axis0();
        apb(1'b1, ADDR_AXIS_CFG, 32'h0025);
        tick(2);
        chk(32'(af[1].homed), 32'h0, "cfg change");
    endtask
    // Channels 0 and 2 exist, channel 2 carries the lower letter
    task automatic t_slots();
        asf_axis_in_t z;
        z = '0;
        z.permit = 1'b1;
        ax[0] <= z;
        z = '0;
        z.in_pos = 1'b1;
        ax[2] <= z;
        ax[1] <= '0;
        tick(3);
        chk(32'(af[0]), 32'h01, "slot1");
        chk(32'(af[1]), 32'h80, "slot2");
        chk(32'(af[2]), 32'h00, "slot3");
        chk({31'h0, zero_flag}, 32'h0, "zero flag");
        chk(32'(all_set), 32'h0, "slot settle");
        chk(32'(plc_on), 32'h2, "plc slots");
        apb(1'b0, ADDR_STATUS, '0);
        chk(rd, 32'h0000_8001, "status word");
    endtask
    task automatic t_spindle();
        apb(1'b1, ADDR_SPIN_CFG, 32'h13);
        sp <= '{permit: 1'b1, dir_neg: 1'b1, stopped: 1'b1, in_pos: 1'b1,
                drive_state: 2'b11, home_done: 1'b1, default: '0};
        tick(1);
        sp.home_done <= 1'b0;
        tick(2);
        chk(32'(sf), 32'h7F, "closed loop");
        apb(1'b1, ADDR_SPD_LOW, 32'h64);
        apb(1'b1, ADDR_SPD_HIGH, 32'hC8);
        sp.speed <= 16'h00C8;
        apb(1'b1, ADDR_SPIN_CFG, 32'h11);
        tick(2);
        chk(32'(sf.homed), 32'h0, "leave closed");
        chk(32'(sf.speed_match), 32'h1, "in window");
        apb(1'b1, ADDR_SPIN_CFG, 32'h12);
        sp.speed <= 16'h00C9;
        tick(2);
        chk(32'(sf.speed_match), 32'h0, "above window");
        sp.drive_error <= 1'b1;
        tick(2);
        chk({30'h0, sf.drive_state_hi, sf.drive_state_lo}, 32'h0, "sp error");
        apb(1'b1, ADDR_SPIN_CFG, 32'h03);
        tick(2);
        chk({30'h0, sf.move_permit, sf.settled}, 32'h0, "deselected");
    endtask

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        tick(20);
        chk(32'(af[0]), 32'h0, "reset flags");
        presetn <= 1'b1;
        t_regs();
        t_axes();
        t_limits();
        t_homing();
        t_slots();
        t_spindle();
        complete_run();
    end
endmodule
